//--- verilog/sqm_pkg.sv
package sqm_pkg;
  // device geometry
  localparam int ADDR_W = 19;
  localparam int LANES = 4;
  localparam int LANE_W = 8;
  localparam int DATA_W = LANES * LANE_W;
  localparam int WORDS = 524288;

  // clock period and device timing figures in ns
  localparam int CLK_PERIOD_NS = 25;
  localparam int MIN_CYCLE_TIME_NS = 25;
  localparam int ADDRESS_ACCESS_TIME_NS = 25;
  localparam int SELECT_ACCESS_TIME_NS = 25;
  localparam int GATE_ACCESS_TIME_NS = 10;
  localparam int STROBE_WRITE_PULSE_NS = 20;
  localparam int STROBE_TO_HIGH_Z_TIME_NS = 10;
  localparam int DATA_SETUP_NS = 15;

  // least times round up to whole cycles, never below one
  function automatic int ns_to_cyc(input int ns);
    int c;
    c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    return (c < 1) ? 1 : c;
  endfunction

  localparam int ACCESS_CYC = ns_to_cyc(SELECT_ACCESS_TIME_NS);
  localparam int HIZ_CYC = ns_to_cyc(STROBE_TO_HIGH_Z_TIME_NS);
  localparam int PULSE_CYC = ns_to_cyc(STROBE_WRITE_PULSE_NS);
  localparam int SETUP_CYC = ns_to_cyc(DATA_SETUP_NS);
  localparam int CYCLE_CYC = ns_to_cyc(MIN_CYCLE_TIME_NS);
  localparam int CNT_W = 4;

  // reset values of the pin drivers
  localparam logic PIN_IDLE = 1'h1;

  // user request carried into the controller
  typedef struct packed {
    logic write;
    logic [LANES-1:0] lanes;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } sqm_req_t;

  // pin group driven toward the memory module
  typedef struct packed {
    logic [LANES-1:0] select_n;
    logic [LANES-1:0] lane_write_strobe_n;
    logic gate_n;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] dout;
    logic [DATA_W-1:0] doe;
  } sqm_pins_t;
endpackage

//--- verilog/sqm_ctrl.sv
module sqm_ctrl
(
  input wire logic CLOCK, // 40 MHz
  input wire logic RST, // synchronous, active high
  input wire logic REQ_VALID, // request offered
  input wire sqm_pkg::sqm_req_t REQ, // request fields
  output logic REQ_READY, // idle, request taken
  output logic [sqm_pkg::DATA_W-1:0] RDATA, // read word
  output logic RDATA_VALID, // one-cycle pulse
  output logic DONE, // write done pulse
  output sqm_pkg::sqm_pins_t PINS, // pins to memory
  input wire logic [sqm_pkg::DATA_W-1:0] DQ_IN // data pin levels
);
  typedef enum logic [2:0] {
    S_IDLE, // pins at rest, ready for a request
    S_RD, // select and gate low, waiting for settled data
    S_WHIZ, // strobe low, waiting for the device to float
    S_WPULSE, // data driven, strobe pulse running
    S_REC // recovery gap before the next access
  } sqm_state_t;

  typedef struct packed {
    sqm_state_t st;
    logic [sqm_pkg::CNT_W-1:0] cnt;
    logic [sqm_pkg::DATA_W-1:0] dq1;
    logic [sqm_pkg::DATA_W-1:0] dq2;
    logic [sqm_pkg::DATA_W-1:0] dq3;
    logic [sqm_pkg::DATA_W-1:0] rdata;
    logic rvalid;
    logic done;
    logic ready;
    sqm_pkg::sqm_pins_t pins;
  } sqm_regs_t;

  // read wait: access time plus two cycles of pin synchroniser
  localparam logic [sqm_pkg::CNT_W-1:0] ACC_N =
    sqm_pkg::CNT_W'(sqm_pkg::ACCESS_CYC + 2);
  // strobe fall to data drive, while the device floats its pins
  localparam logic [sqm_pkg::CNT_W-1:0] HIZ_N =
    sqm_pkg::CNT_W'(sqm_pkg::HIZ_CYC);
  // data held under a low strobe: setup and pulse width together
  localparam logic [sqm_pkg::CNT_W-1:0] PUL_N =
    sqm_pkg::CNT_W'(sqm_pkg::PULSE_CYC + sqm_pkg::SETUP_CYC);
  // quiet time before the next select fall
  localparam logic [sqm_pkg::CNT_W-1:0] REC_N =
    sqm_pkg::CNT_W'(sqm_pkg::CYCLE_CYC);

  sqm_regs_t s_r, s_nxt;

  // pins at rest: every lane deselected, no strobe, gate high and
  // nothing driven, so the device floats its outputs from the start
  localparam sqm_pkg::sqm_pins_t PINS_IDLE = '{
    select_n: {sqm_pkg::LANES{sqm_pkg::PIN_IDLE}},
    lane_write_strobe_n: {sqm_pkg::LANES{sqm_pkg::PIN_IDLE}},
    gate_n: sqm_pkg::PIN_IDLE,
    addr: '0,
    dout: '0,
    doe: '0
  };

  // per-bit view of the selected lanes, from the registered selects
  wire [sqm_pkg::DATA_W-1:0] lane_bits;
  for (genvar i = 0; i < sqm_pkg::LANES; i++)
  begin : g_lane
    // each byte lane follows its own select
    assign lane_bits[i*sqm_pkg::LANE_W +: sqm_pkg::LANE_W] =
      {sqm_pkg::LANE_W{~s_r.pins.select_n[i]}};
  end

  // read data settles once the last two sync flops agree; released
  // lanes wander, so only the selected ones are compared
  logic rd_settled;
  assign rd_settled = ((s_r.dq2 ^ s_r.dq3) & lane_bits) == '0;

  // a request is taken only in idle, with ready already shown
  logic take;
  assign take = s_r.st == S_IDLE && REQ_VALID && s_r.ready;

  // next-state logic for the whole controller
  always_comb
  begin
    s_nxt = s_r;
    // answer pulses drop after one cycle unless a state raises them
    s_nxt.rvalid = 1'h0;
    s_nxt.done = 1'h0;
    // pin data passes three flops; settled when last two agree
    s_nxt.dq1 = DQ_IN;
    s_nxt.dq2 = s_r.dq1;
    s_nxt.dq3 = s_r.dq2;
    if (s_r.cnt != '0)
      s_nxt.cnt = s_r.cnt - sqm_pkg::CNT_W'(1);
    // each state changes only the pins it owns; the rest hold
    case (s_r.st)
      S_IDLE:
      begin
        // ready stands in idle until a request is taken
        s_nxt.ready = 1'h1;
        if (take)
        begin
          s_nxt.ready = 1'h0;
          // address set with the select fall, held all cycle
          s_nxt.pins.addr = REQ.addr;
          // chosen lanes share select and strobe
          s_nxt.pins.select_n = ~REQ.lanes;
          if (REQ.write)
          begin
            // gate high so the pins are already floating
            s_nxt.pins.gate_n = 1'h1;
            s_nxt.pins.lane_write_strobe_n = ~REQ.lanes;
            // data waits in the pin register, not yet driven
            s_nxt.pins.dout = REQ.wdata;
            s_nxt.st = S_WHIZ;
            s_nxt.cnt = HIZ_N;
          end
          else
          begin
            // select-led read: gate low, strobe high, address steady
            s_nxt.pins.gate_n = 1'h0;
            s_nxt.pins.lane_write_strobe_n = {sqm_pkg::LANES{1'h1}};
            s_nxt.st = S_RD;
            s_nxt.cnt = ACC_N;
          end
        end
      end
      S_RD:
      begin
        // extra two cycles cover the pin synchroniser delay
        if (s_r.cnt == '0 && rd_settled)
        begin
          s_nxt.rdata = s_r.dq3 & lane_bits; // unselected lanes read 0
          s_nxt.rvalid = 1'h1;
          s_nxt.pins.select_n = {sqm_pkg::LANES{1'h1}};
          s_nxt.pins.gate_n = 1'h1;
          s_nxt.st = S_REC;
          s_nxt.cnt = REC_N;
        end
      end
      S_WHIZ:
      begin
        // drive data only after the device has let go of the pins;
        // the gate is high already, the wait only guards the strobe fall
        if (s_r.cnt == '0)
        begin
          // only selected lanes drive; the rest stay released
          s_nxt.pins.doe = lane_bits;
          s_nxt.st = S_WPULSE;
          s_nxt.cnt = PUL_N;
        end
      end
      S_WPULSE:
      begin
        // pulse counted from the start of data drive, after the high-Z wait
        if (s_r.cnt == '0)
        begin
          s_nxt.pins.lane_write_strobe_n = {sqm_pkg::LANES{1'h1}};
          s_nxt.st = S_REC;
          s_nxt.cnt = REC_N;
          s_nxt.done = 1'h1;
        end
      end
      S_REC:
      begin
        // strobe rose first, so data hold and select rise follow
        s_nxt.pins.select_n = {sqm_pkg::LANES{1'h1}};
        s_nxt.pins.doe = '0;
        if (s_r.cnt == '0)
        begin
          s_nxt.st = S_IDLE;
          s_nxt.ready = 1'h1;
        end
      end
      default:
        s_nxt.st = S_IDLE;
    endcase
  end

  // single state register; pins idle high and floating on reset
  // no clock enable: every register moves on every edge
  always_ff @(posedge CLOCK)
  begin
    if (RST)
    begin
      // constants only; ready rises one edge after release
      s_r <= '{
        st: S_IDLE,
        cnt: '0,
        dq1: '0,
        dq2: '0,
        dq3: '0,
        rdata: '0,
        rvalid: 1'h0,
        done: 1'h0,
        ready: 1'h0,
        pins: PINS_IDLE
      };
    end
    else
      s_r <= s_nxt;
  end

  // outputs straight from flops
  assign REQ_READY = s_r.ready;
  assign RDATA = s_r.rdata;
  assign RDATA_VALID = s_r.rvalid;
  assign DONE = s_r.done;
  assign PINS = s_r.pins;
endmodule

//--- sim/sqm_ctrl_props.sv
module sqm_ctrl_props
(
  input wire logic CLOCK, // clock
  input wire logic RST, // reset
  input wire logic REQ_READY, // idle
  input wire logic RDATA_VALID, // read answer pulse
  input wire logic DONE, // write done
  input wire sqm_pkg::sqm_pins_t PINS // memory pins
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge CLOCK); endclocking
  default disable iff (RST);
  // strobes travel only with their lane select
  chk_lane_pair: assert property (
    (~PINS.lane_write_strobe_n & PINS.select_n) == '0) else $error("strobe");
  chk_addr_hold: assert property (
    |~PINS.select_n && $past(|~PINS.select_n) |-> $stable(PINS.addr))
    else $error("addr moved");
  chk_read_quiet: assert property (
    !PINS.gate_n |-> &PINS.lane_write_strobe_n && PINS.doe == '0)
    else $error("gate with drive");
  // drive only once the device pins have gone quiet
  chk_hiz_wait: assert property (
    $rose(|PINS.doe) |-> $past(~&PINS.lane_write_strobe_n) && PINS.gate_n)
    else $error("early drive");
  chk_data_setup: assert property (
    $rose(&PINS.lane_write_strobe_n) |-> $past(|PINS.doe))
    else $error("no setup");
  chk_sel_end: assert property (
    $rose(&PINS.select_n) |-> $past(&PINS.lane_write_strobe_n))
    else $error("select ended write");
  chk_done_pulse: assert property (
    DONE |-> &PINS.lane_write_strobe_n ##1 !DONE) else $error("done");
  chk_idle_pins: assert property (
    REQ_READY |-> &PINS.select_n && PINS.doe == '0) else $error("idle");
  // no read answer before the access time and synchroniser have run
  chk_read_wait: assert property (
    $fell(PINS.gate_n) |-> !RDATA_VALID [*4])
    else $error("read answered early");
  chk_rvalid_pulse: assert property (
    RDATA_VALID |-> (&PINS.select_n && PINS.gate_n) ##1 !RDATA_VALID)
    else $error("read end");
endmodule
bind sqm_ctrl sqm_ctrl_props u_props (.CLOCK(CLOCK), .RST(RST),
  .REQ_READY(REQ_READY), .RDATA_VALID(RDATA_VALID), .DONE(DONE),
  .PINS(PINS));

//--- sim/sqm_mem.sv
module sqm_mem
(
  input wire sqm_pkg::sqm_pins_t pins, // controller pins
  input wire logic [31:0] dq, // resolved data wire
  output logic [31:0] q, // read drive
  output logic [31:0] qe // drive enable per bit
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] mem [bit [20:0]]; // sparse, four lanes of 524288
  for (genvar i = 0; i < 4; i++)
  begin : g_lane
    // drive only when selected, gated and not writing
    assign qe[8*i+:8] = {8{!pins.select_n[i] && !pins.gate_n &&
      pins.lane_write_strobe_n[i]}};
    // data lags the last change by the access time
    always @(pins)
      q[8*i+:8] <= #(sqm_pkg::ADDRESS_ACCESS_TIME_NS) mem[{2'(i), pins.addr}];
    // store when the earlier of strobe or select ends
    always @(posedge pins.lane_write_strobe_n[i] or posedge pins.select_n[i])
      if (pins.select_n[i] ^ pins.lane_write_strobe_n[i])
        mem[{2'(i), pins.addr}] = dq[8*i+:8];
  end
endmodule

//--- sim/tb.sv
`define CMP(a, b) begin n_compared++; if ((a) !== (b)) begin fails++; \
  $display("BAD %0t %h %h", $time, a, b); end end
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {sqm_pkg::sqm_req_t r; logic [31:0] exp;} sqm_row_t;
  logic CLOCK = 1'h0;
  logic RST = 1'h1;
  logic REQ_VALID = 1'h0;
  sqm_pkg::sqm_req_t REQ = '0;
  logic REQ_READY, RDATA_VALID, DONE;
  logic [31:0] RDATA, q, qe, dq;
  logic [31:0] flt = 32'h5a5a5a5a;
  sqm_pkg::sqm_pins_t PINS;
  int fails = 0;
  int n_compared = 0;
  sqm_row_t rows [7] = '{
    '{'{1'h1, 4'hf, 19'h0, 32'h11223344}, 32'h0},
    '{'{1'h1, 4'h1, 19'h7ffff, 32'h000000aa}, 32'h0},
    '{'{1'h1, 4'h6, 19'h7ffff, 32'h00bbcc00}, 32'h0},
    '{'{1'h0, 4'hf, 19'h0, 32'h0}, 32'h11223344},
    '{'{1'h1, 4'h8, 19'h0, 32'hee000000}, 32'h0},
    '{'{1'h0, 4'h7, 19'h7ffff, 32'h0}, 32'h00bbccaa},
    '{'{1'h0, 4'hf, 19'h0, 32'h0}, 32'hee223344}};
  sqm_ctrl dut (.CLOCK(CLOCK), .RST(RST), .REQ_VALID(REQ_VALID), .REQ(REQ),
    .REQ_READY(REQ_READY), .RDATA(RDATA), .RDATA_VALID(RDATA_VALID),
    .DONE(DONE), .PINS(PINS), .DQ_IN(dq));
  sqm_mem u_mem (.pins(PINS), .dq(dq), .q(q), .qe(qe));
  // released bits wander so a stale level never reads as data
  always @(posedge CLOCK) flt <= ~flt;
  assign dq = PINS.doe & PINS.dout | ~PINS.doe & (qe & q | ~qe & flt);
  initial
  begin
    forever #12.5 CLOCK = ~CLOCK;
  end
  task automatic test_done;
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // offer at a falling edge, wait for ready, then for the answer pulse
  task automatic op(input sqm_pkg::sqm_req_t r);
    int k;
    REQ = r;
    REQ_VALID = 1'h1;
    for (k = 0; k < 60 && REQ_READY !== 1'h1; k++) @(negedge CLOCK);
    if (k == 60)
    begin
      fails++;
      test_done;
    end
    @(negedge CLOCK);
    REQ_VALID = 1'h0;
    for (k = 0; k < 60 && (r.write ? DONE : RDATA_VALID) !== 1'h1; k++)
      @(negedge CLOCK);
    if (k == 60)
    begin
      fails++;
      test_done;
    end
  endtask
  function automatic logic [31:0] m(input logic [3:0] l);
    return {{8{l[3]}}, {8{l[2]}}, {8{l[1]}}, {8{l[0]}}};
  endfunction
  initial
  begin
    repeat (6) @(negedge CLOCK);
    RST = 1'h0;
    @(negedge CLOCK);
    `CMP(PINS.select_n, 4'hf)
    `CMP(PINS.doe, 32'h0)
    foreach (rows[i])
    begin
      op(rows[i].r);
      if (!rows[i].r.write)
        `CMP(RDATA & m(rows[i].r.lanes), rows[i].exp)
      $display("row %0d done", i);
    end
    // reset lands in the middle of a read
    REQ = rows[3].r;
    REQ_VALID = 1'h1;
    repeat (3) @(negedge CLOCK);
    REQ_VALID = 1'h0;
    RST = 1'h1;
    @(negedge CLOCK);
    RST = 1'h0;
    `CMP(PINS.gate_n, 1'h1)
    op(rows[6].r);
    `CMP(RDATA, rows[6].exp)
    $display("reset test done");
    test_done;
  end
endmodule
